// File: delr_error_log.v
// disk error log recorder: command history, five-entry summary log, log request checks
`include "delr_consts.vh"

module delr_error_log #(
    parameter MULTI_SECTOR = 1,
    parameter [31:0] MS_CYCLES = `DELR_MS_NS / `DELR_CLK_PERIOD_NS,
    parameter [31:0] MS_PER_HOUR = `DELR_HOUR_MS,
    parameter [3:0] STATE_VENDOR = 4'h0
) (
    // clock and reset
    input wire REF_CLK_I,
    input wire RESETN_I,
    // command or reset acceptance, task file at command write
    input wire CMD_ACCEPT_I,
    input wire CMD_HW_RESET_I,
    input wire [7:0] TF_DEVCTL_I,
    input wire [7:0] TF_FEAT_I,
    input wire [7:0] TF_SCNT_I,
    input wire [7:0] TF_SNUM_I,
    input wire [7:0] TF_CYLL_I,
    input wire [7:0] TF_CYLH_I,
    input wire [7:0] TF_DEVHD_I,
    input wire [7:0] TF_CMD_I,
    input wire [3:0] DEV_STATE_I,
    // command completion
    input wire CMP_DONE_I,
    input wire CMP_DEV_FAULT_I,
    input wire CMP_HOST_FAULT_I,
    input wire [7:0] CMP_ERROR_I,
    input wire [7:0] CMP_SCNT_I,
    input wire [7:0] CMP_SNUM_I,
    input wire [7:0] CMP_CYLL_I,
    input wire [7:0] CMP_CYLH_I,
    input wire [7:0] CMP_DEVHD_I,
    input wire [7:0] CMP_STATUS_I,
    // log read and write requests
    input wire LOG_REQ_I,
    input wire LOG_WRITE_I,
    input wire [7:0] LOG_ADDR_I,
    input wire [7:0] LOG_SCNT_I,
    // request answers and sector data
    output reg LOG_ACK_O,
    output reg LOG_FWD_O,
    output reg LOG_ABORT_O,
    output reg BUSY_O,
    output reg [7:0] DATA_O,
    output reg DATA_VALID_O,
    output reg DATA_LAST_O
);

    // ----------------------------------------------------------------
    // states and helpers
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_READ = 3'b010;
    localparam [2:0] ST_LOG = 3'b100;

    // first byte of an entry slot within the sector
    function [8:0] entry_base;
        input [2:0] slot;
        begin
            entry_base = `DELR_OFS_ENTRY0 + `DELR_ENTRY_LEN * slot;
        end
    endfunction

    // host-owned log address range
    function is_host_log;
        input [7:0] addr;
        begin
            is_host_log = (addr >= `DELR_ADDR_HOST_LO) && (addr <= `DELR_ADDR_HOST_HI);
        end
    endfunction

    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg [31:0] cyc_reg;
    reg [31:0] ms_reg;
    reg [31:0] hr_ms_reg;
    reg [15:0] hours_reg;
    reg [63:0] rec_tf [0:4];
    reg [31:0] rec_ts [0:4];
    reg [4:0] rec_hw_reg;
    reg [4:0] rec_vld_reg;
    reg [3:0] cur_state_reg;
    reg [63:0] snap_tf [0:4];
    reg [31:0] snap_ts [0:4];
    reg [4:0] snap_hw_reg;
    reg [4:0] snap_vld_reg;
    reg [55:0] snap_cmp_reg;
    reg [3:0] snap_state_reg;
    reg [15:0] snap_life_reg;
    reg pend_reg;
    reg pend_next;
    reg [7:0] mem [0:`DELR_MEM_BYTES-1];
    reg [2:0] wr_slot_reg;
    reg [7:0] idx_reg;
    reg [4:0] used_reg;
    reg [15:0] count_reg;
    reg [8:0] wr_addr_reg;
    reg [6:0] k_reg;
    reg [2:0] rec_reg;
    reg [3:0] sub_reg;
    reg [8:0] ptr_reg;
    reg [7:0] sum_reg;
    reg dir_reg;
    reg [7:0] ent_byte;
    reg [7:0] rd_byte;
    reg [2:0] rd_slot;
    reg [63:0] tf_sel;
    reg [31:0] ts_sel;
    reg [6:0] err_ofs;
    reg [3:0] state_clean;
    integer i;

    wire st_idle = st_reg[0];
    wire st_log = st_reg[2];
    // device-caused failures only; host-caused ones never reach the log
    wire fail_ev = CMP_DONE_I & CMP_DEV_FAULT_I & ~CMP_HOST_FAULT_I;
    // a second failure while one is still pending is dropped (needs two completions within ~600 cycles)
    wire fail_take = fail_ev & ~st_log & ~pend_reg;
    wire take_req = LOG_REQ_I & st_idle & ~pend_reg;
    wire bad_cnt = (LOG_SCNT_I == 8'h00);
    wire rd_dir = (LOG_ADDR_I == `DELR_ADDR_DIR);
    wire rd_sum = (LOG_ADDR_I == `DELR_ADDR_SUMMARY);
    wire req_here = ~LOG_WRITE_I & (rd_sum | (rd_dir & (MULTI_SECTOR != 0)));
    wire req_fwd = is_host_log(LOG_ADDR_I);
    // log zero is reserved without multi-sector support; only host logs are writable
    wire req_abort = bad_cnt | ~(req_here | req_fwd);

    // ----------------------------------------------------------------
    // next state and pending failure
    // ----------------------------------------------------------------
    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (pend_reg)
                    st_next = ST_LOG;
                else if (take_req && req_here && !bad_cnt)
                    st_next = ST_READ;
            end
            ST_READ: begin
                if (ptr_reg == `DELR_OFS_CKSUM)
                    st_next = ST_IDLE;
            end
            ST_LOG: begin
                if (k_reg == `DELR_ENTRY_LAST)
                    st_next = ST_IDLE;
            end
            default: st_next = ST_IDLE;
        endcase
        pend_next = fail_take ? 1'b1 : ((st_idle && pend_reg) ? 1'b0 : pend_reg);
    end

    // reserved state codes are reported as unknown
    always @* begin
        if (DEV_STATE_I > `DELR_STATE_OFFLINE && DEV_STATE_I < `DELR_STATE_VENDOR_LO)
            state_clean = `DELR_STATE_UNKNOWN;
        else
            state_clean = DEV_STATE_I;
    end

    // ----------------------------------------------------------------
    // entry byte builder, walked by rec_reg/sub_reg/k_reg
    // ----------------------------------------------------------------
    always @* begin
        ent_byte = 8'h00;
        tf_sel = snap_tf[rec_reg];
        ts_sel = snap_ts[rec_reg];
        err_ofs = k_reg - `DELR_ERR_OFS;
        if (k_reg < `DELR_ERR_OFS) begin
            // older records that never existed stay zero
            if (snap_vld_reg[rec_reg]) begin
                if (sub_reg >= `DELR_REC_TS)
                    ent_byte = ts_sel[{sub_reg[1:0], 3'b000} +: 8];
                else if (snap_hw_reg[rec_reg])
                    ent_byte = (sub_reg == 4'h0) ? `DELR_HW_RESET_MARK : 8'h00;
                else
                    ent_byte = tf_sel[{sub_reg[2:0], 3'b000} +: 8];
            end
        end else begin
            // reserved and vendor bytes are zero; hardware reset hides captured registers
            if (err_ofs != 7'h00 && err_ofs <= `DELR_ERR_CAP_LAST) begin
                if (!snap_hw_reg[`DELR_CMD_RECS-1])
                    ent_byte = snap_cmp_reg[{err_ofs[2:0] - 3'h1, 3'b000} +: 8];
            end else if (err_ofs == `DELR_ERR_STATE)
                ent_byte = {STATE_VENDOR, snap_state_reg};
            else if (err_ofs == `DELR_ERR_LIFE_LO)
                ent_byte = snap_life_reg[7:0];
            else if (err_ofs == `DELR_ERR_LIFE_HI)
                ent_byte = snap_life_reg[15:8];
        end
    end

    // ----------------------------------------------------------------
    // sector byte for the read stream
    // ----------------------------------------------------------------
    always @* begin
        rd_byte = 8'h00;
        rd_slot = 3'h0;
        for (i = 1; i < `DELR_ENTRY_SLOTS; i = i + 1) begin
            if (ptr_reg >= entry_base(i[2:0]))
                rd_slot = i[2:0];
        end
        if (dir_reg) begin
            if (ptr_reg == `DELR_OFS_VERSION)
                rd_byte = `DELR_LOG_VERSION;
            else if (!ptr_reg[0] && ptr_reg[8:1] == `DELR_ADDR_SUMMARY)
                rd_byte = `DELR_SUMMARY_SECTORS;
            else if (!ptr_reg[0] && is_host_log(ptr_reg[8:1]))
                rd_byte = `DELR_HOST_LOG_SECTORS;
        end else begin
            // the summary is the only store, so it holds at most the newest five logged failures
            case (ptr_reg)
                `DELR_OFS_VERSION: rd_byte = `DELR_LOG_VERSION;
                `DELR_OFS_INDEX: rd_byte = idx_reg;
                `DELR_OFS_CNT_LO: rd_byte = count_reg[7:0];
                `DELR_OFS_CNT_HI: rd_byte = count_reg[15:8];
                `DELR_OFS_CKSUM: rd_byte = 8'h00 - sum_reg;
                default: begin
                    // slots never written read zero without clearing the array
                    if (ptr_reg >= `DELR_OFS_ENTRY0 && ptr_reg < `DELR_OFS_CNT_LO && used_reg[rd_slot])
                        rd_byte = mem[ptr_reg - `DELR_OFS_ENTRY0];
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // power-on millisecond and lifetime hour counters
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cyc_reg <= 32'h0000_0000;
            ms_reg <= 32'h0000_0000;
            hr_ms_reg <= 32'h0000_0000;
            hours_reg <= 16'h0000;
        end else if (cyc_reg == MS_CYCLES - 32'h0000_0001) begin
            cyc_reg <= 32'h0000_0000;
            ms_reg <= ms_reg + 32'h0000_0001; // wraps freely
            if (hr_ms_reg == MS_PER_HOUR - 32'h0000_0001) begin
                hr_ms_reg <= 32'h0000_0000;
                hours_reg <= hours_reg + 16'h0001;
            end else begin
                hr_ms_reg <= hr_ms_reg + 32'h0000_0001;
            end
        end else begin
            cyc_reg <= cyc_reg + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // command history and failure snapshot
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (i = 0; i < `DELR_CMD_RECS; i = i + 1) begin
                rec_tf[i] <= 64'h0000_0000_0000_0000;
                rec_ts[i] <= 32'h0000_0000;
                snap_tf[i] <= 64'h0000_0000_0000_0000;
                snap_ts[i] <= 32'h0000_0000;
            end
            rec_hw_reg <= 5'h00;
            rec_vld_reg <= 5'h00;
            cur_state_reg <= `DELR_STATE_UNKNOWN;
            snap_hw_reg <= 5'h00;
            snap_vld_reg <= 5'h00;
            snap_cmp_reg <= 56'h00_0000_0000_0000;
            snap_state_reg <= `DELR_STATE_UNKNOWN;
            snap_life_reg <= 16'h0000;
        end else begin
            // snapshot first: a command accepted in the same cycle is not part of this failure
            if (fail_take) begin
                for (i = 0; i < `DELR_CMD_RECS; i = i + 1) begin
                    snap_tf[i] <= rec_tf[i];
                    snap_ts[i] <= rec_ts[i];
                end
                snap_hw_reg <= rec_hw_reg;
                snap_vld_reg <= rec_vld_reg;
                snap_state_reg <= cur_state_reg;
                snap_life_reg <= hours_reg;
                snap_cmp_reg <= {CMP_STATUS_I, CMP_DEVHD_I, CMP_CYLH_I, CMP_CYLL_I,
                                 CMP_SNUM_I, CMP_SCNT_I, CMP_ERROR_I};
            end
            // oldest record drops out at index 0, newest enters at index 4
            if (CMD_ACCEPT_I) begin
                for (i = 0; i < `DELR_CMD_RECS - 1; i = i + 1) begin
                    rec_tf[i] <= rec_tf[i + 1];
                    rec_ts[i] <= rec_ts[i + 1];
                end
                rec_tf[`DELR_CMD_RECS-1] <= {TF_CMD_I, TF_DEVHD_I, TF_CYLH_I, TF_CYLL_I,
                                             TF_SNUM_I, TF_SCNT_I, TF_FEAT_I, TF_DEVCTL_I};
                rec_ts[`DELR_CMD_RECS-1] <= ms_reg;
                rec_hw_reg <= {CMD_HW_RESET_I, rec_hw_reg[4:1]};
                rec_vld_reg <= {1'b1, rec_vld_reg[4:1]};
                cur_state_reg <= state_clean;
            end
        end
    end

    // entry bytes land in the slot being written; contents are masked by used_reg
    always @(posedge REF_CLK_I) begin
        if (st_log)
            mem[wr_addr_reg] <= ent_byte;
    end

    // ----------------------------------------------------------------
    // sequencer: entry writing, sector streaming, request answers
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            wr_slot_reg <= 3'h0;
            idx_reg <= `DELR_INDEX_RST;
            used_reg <= 5'h00;
            count_reg <= 16'h0000;
            wr_addr_reg <= 9'h000;
            k_reg <= 7'h00;
            rec_reg <= 3'h0;
            sub_reg <= 4'h0;
            ptr_reg <= 9'h000;
            sum_reg <= 8'h00;
            dir_reg <= 1'b0;
            LOG_ACK_O <= 1'b0;
            LOG_FWD_O <= 1'b0;
            LOG_ABORT_O <= 1'b0;
            BUSY_O <= 1'b0;
            DATA_O <= 8'h00;
            DATA_VALID_O <= 1'b0;
            DATA_LAST_O <= 1'b0;
        end else begin
            st_reg <= st_next;
            pend_reg <= pend_next;
            BUSY_O <= (st_next != ST_IDLE) | pend_next;
            LOG_ACK_O <= take_req & req_here & ~bad_cnt;
            LOG_FWD_O <= take_req & req_fwd & ~bad_cnt;
            LOG_ABORT_O <= take_req & req_abort;
            DATA_VALID_O <= st_reg[1];
            DATA_LAST_O <= st_reg[1] & (ptr_reg == `DELR_OFS_CKSUM);
            if (st_reg[1])
                DATA_O <= rd_byte;
            // start of a sector stream
            if (st_idle && st_next == ST_READ) begin
                ptr_reg <= 9'h000;
                sum_reg <= 8'h00;
                dir_reg <= rd_dir;
            end
            if (st_reg[1]) begin
                ptr_reg <= ptr_reg + 9'h001;
                sum_reg <= sum_reg + rd_byte;
            end
            // start of an entry write into the next ring slot
            if (st_idle && pend_reg) begin
                wr_addr_reg <= entry_base(wr_slot_reg) - `DELR_OFS_ENTRY0;
                k_reg <= 7'h00;
                rec_reg <= 3'h0;
                sub_reg <= 4'h0;
            end
            if (st_log) begin
                wr_addr_reg <= wr_addr_reg + 9'h001;
                k_reg <= k_reg + 7'h01;
                if (sub_reg == `DELR_REC_LAST) begin
                    sub_reg <= 4'h0;
                    rec_reg <= rec_reg + 3'h1;
                end else begin
                    sub_reg <= sub_reg + 4'h1;
                end
                // entry complete: publish it, advance the ring, count the failure
                if (k_reg == `DELR_ENTRY_LAST) begin
                    used_reg[wr_slot_reg] <= 1'b1;
                    idx_reg <= {5'h00, wr_slot_reg + 3'h1};
                    wr_slot_reg <= (wr_slot_reg == `DELR_ENTRY_SLOTS - 3'h1) ? 3'h0 : wr_slot_reg + 3'h1;
                    if (count_reg != `DELR_COUNT_MAX)
                        count_reg <= count_reg + 16'h0001;
                end
            end
        end
    end

endmodule // delr_error_log

// File: delr_consts.vh
// constants for the disk error log recorder: sector layout, codes, timing
`ifndef DELR_CONSTS_VH
`define DELR_CONSTS_VH

// ----------------------------------------------------------------
// summary sector layout (byte offsets)
// ----------------------------------------------------------------
`define DELR_OFS_VERSION 9'h000
`define DELR_OFS_INDEX 9'h001
`define DELR_OFS_ENTRY0 9'h002
`define DELR_OFS_CNT_LO 9'h1C4
`define DELR_OFS_CNT_HI 9'h1C5
`define DELR_OFS_CKSUM 9'h1FF
`define DELR_ENTRY_LEN 9'h05A
`define DELR_ENTRY_SLOTS 3'h5
`define DELR_MEM_BYTES 450

// ----------------------------------------------------------------
// layout inside one entry
// ----------------------------------------------------------------
`define DELR_REC_LAST 4'hB
`define DELR_REC_TS 4'h8
`define DELR_CMD_RECS 3'h5
`define DELR_ERR_OFS 7'h3C
`define DELR_ENTRY_LAST 7'h59
`define DELR_ERR_CAP_LAST 7'h07
`define DELR_ERR_STATE 7'h1B
`define DELR_ERR_LIFE_LO 7'h1C
`define DELR_ERR_LIFE_HI 7'h1D

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define DELR_LOG_VERSION 8'h01
`define DELR_HW_RESET_MARK 8'hFF
`define DELR_HOST_LOG_SECTORS 8'h10
`define DELR_SUMMARY_SECTORS 8'h01
`define DELR_ADDR_DIR 8'h00
`define DELR_ADDR_SUMMARY 8'h01
`define DELR_ADDR_HOST_LO 8'h80
`define DELR_ADDR_HOST_HI 8'h9F
`define DELR_STATE_UNKNOWN 4'h0
`define DELR_STATE_OFFLINE 4'h4
`define DELR_STATE_VENDOR_LO 4'hB
`define DELR_INDEX_RST 8'h00
`define DELR_COUNT_MAX 16'hFFFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DELR_CLK_PERIOD_NS 20
`define DELR_MS_NS 1000000
`define DELR_HOUR_MS 3600000

`endif

// File: delr_asserts.sv
// port checker for the disk error log recorder
module delr_asserts (
    // clock, reset, requests and completions
    input wire REF_CLK_I,
    input wire RESETN_I,
    input wire LOG_REQ_I,
    input wire LOG_WRITE_I,
    input wire [7:0] LOG_ADDR_I,
    input wire [7:0] LOG_SCNT_I,
    input wire CMP_DONE_I,
    input wire CMP_DEV_FAULT_I,
    input wire CMP_HOST_FAULT_I,
    // answers and stream
    input wire LOG_ACK_O,
    input wire LOG_FWD_O,
    input wire LOG_ABORT_O,
    input wire BUSY_O,
    input wire DATA_VALID_O,
    input wire DATA_LAST_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] byte_cnt_reg;
    logic [8:0] byte_cnt_next;
    wire req_taken = LOG_REQ_I && !BUSY_O;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // bytes seen since the last read was accepted
    assign byte_cnt_next = LOG_ACK_O ? 9'h000 : DATA_VALID_O ? byte_cnt_reg + 9'h001 : byte_cnt_reg;
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            byte_cnt_reg <= 9'h000;
        end else begin
            byte_cnt_reg <= byte_cnt_next;
        end
    end
    req_answer_a:
        assert property (req_taken |=> (LOG_ACK_O || LOG_FWD_O || LOG_ABORT_O)) else $error("request unanswered");
    zero_count_abort_a:
        assert property (req_taken && LOG_SCNT_I == 8'h00 |=> LOG_ABORT_O) else $error("zero count not aborted");
    dir_read_ack_a:
        assert property (req_taken && !LOG_WRITE_I && LOG_ADDR_I == 8'h00 && LOG_SCNT_I != 8'h00 |=> LOG_ACK_O)
        else $error("directory read refused");
    host_log_fwd_a:
        assert property (req_taken && LOG_SCNT_I != 8'h00 && LOG_ADDR_I[7:5] == 3'b100 |=> LOG_FWD_O)
        else $error("host log not forwarded");
    ack_stream_a:
        assert property (LOG_ACK_O |-> BUSY_O ##1 DATA_VALID_O [*8]) else $error("stream not started");
    sector_len_a:
        assert property (DATA_LAST_O |-> DATA_VALID_O && byte_cnt_reg == 9'd511) else $error("sector length wrong");
    last_stop_a:
        assert property (DATA_LAST_O |=> !DATA_VALID_O) else $error("stream runs past last byte");
    host_fault_skip_a:
        assert property (CMP_DONE_I && CMP_HOST_FAULT_I && !BUSY_O && !LOG_REQ_I |=> !BUSY_O)
        else $error("host fault was logged");
    dev_fault_log_a:
        assert property (CMP_DONE_I && CMP_DEV_FAULT_I && !CMP_HOST_FAULT_I && !BUSY_O |=> BUSY_O [*8])
        else $error("device fault not logged");
    cover property (LOG_ACK_O);
    cover property (LOG_FWD_O);
    cover property (LOG_ABORT_O);
    cover property (CMP_DONE_I && CMP_DEV_FAULT_I);
endmodule // delr_asserts

bind delr_error_log delr_asserts u_chk (.REF_CLK_I, .RESETN_I, .LOG_REQ_I, .LOG_WRITE_I, .LOG_ADDR_I, .LOG_SCNT_I,
    .CMP_DONE_I, .CMP_DEV_FAULT_I, .CMP_HOST_FAULT_I, .LOG_ACK_O, .LOG_FWD_O, .LOG_ABORT_O, .BUSY_O,
    .DATA_VALID_O, .DATA_LAST_O);

// File: delr_host_model.sv
// host adapter model issuing log read and write requests
module delr_host_model (
    // clock and answers
    input wire clk_i,
    input wire busy_i,
    input wire ack_i,
    input wire fwd_i,
    input wire abort_i,
    input wire [7:0] data_i,
    input wire valid_i,
    input wire last_i,
    // log request
    output logic req_o = 1'b0,
    output logic write_o = 1'b0,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] scnt_o = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] res;
    int nb;
    logic [7:0] sec [512];
    // one request: answer code 1 accept, 2 forward, 3 abort; accepted sector lands in sec
    task automatic request(input logic w, input logic [7:0] a, input logic [7:0] s);
        int k;
        res = 2'd0;
        nb = 0;
        k = 0;
        @(posedge clk_i);
        #1;
        while (busy_i !== 1'b0 && k < 2000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        @(posedge clk_i);
        req_o <= 1'b1;
        write_o <= w;
        addr_o <= a;
        scnt_o <= s;
        @(posedge clk_i);
        req_o <= 1'b0;
        // released lines carry the inverse so a stale value never passes for a live one
        write_o <= ~w;
        addr_o <= ~a;
        scnt_o <= ~s;
        for (k = 0; k < 3 && res == 2'd0; k++) begin
            #1;
            res = ack_i ? 2'd1 : fwd_i ? 2'd2 : abort_i ? 2'd3 : 2'd0;
            if (res == 2'd0) @(posedge clk_i);
        end
        k = 0;
        while (res == 2'd1 && k < 600) begin
            @(posedge clk_i);
            #1;
            k++;
            if (valid_i === 1'b1) begin
                sec[nb] = data_i;
                nb++;
                if (last_i === 1'b1) k = 600;
            end
        end
    endtask
endmodule // delr_host_model

// File: disk_error_log_recorder_test.sv
// self-checking testbench for the disk error log recorder
module disk_error_log_recorder_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic acc = 1'b0;
    logic hw = 1'b0;
    logic [3:0] dstate = 4'h0;
    logic done = 1'b0;
    logic dflt = 1'b0;
    logic hflt = 1'b0;
    logic [7:0] tf [8];
    logic [7:0] cm [7];
    wire req, wr, ack, fwd, abrt, busy, dv, dl;
    wire [7:0] addr, scnt, dat;
    int n_mismatch = 0;
    int cmp_count = 0;
    int i;
    // rows: write, address, count, answer (1 accept, 2 forward, 3 abort)
    logic [18:0] rows [10] = '{{1'b0, 8'h00, 8'h01, 2'd1}, {1'b0, 8'h01, 8'h01, 2'd1}, {1'b0, 8'h02, 8'h01, 2'd3},
        {1'b0, 8'h06, 8'h01, 2'd3}, {1'b0, 8'h80, 8'h01, 2'd2}, {1'b1, 8'h9F, 8'h02, 2'd2},
        {1'b1, 8'h01, 8'h01, 2'd3}, {1'b0, 8'h01, 8'h00, 2'd3}, {1'b1, 8'h80, 8'h00, 2'd3},
        {1'b0, 8'hA0, 8'h01, 2'd3}};
    initial forever #10 clk = ~clk;
    delr_error_log #(.MS_CYCLES(32'd4), .MS_PER_HOUR(32'd3)) u_dut (.REF_CLK_I(clk), .RESETN_I(rst_n),
        .CMD_ACCEPT_I(acc), .CMD_HW_RESET_I(hw), .TF_DEVCTL_I(tf[0]), .TF_FEAT_I(tf[1]), .TF_SCNT_I(tf[2]),
        .TF_SNUM_I(tf[3]), .TF_CYLL_I(tf[4]), .TF_CYLH_I(tf[5]), .TF_DEVHD_I(tf[6]), .TF_CMD_I(tf[7]),
        .DEV_STATE_I(dstate), .CMP_DONE_I(done), .CMP_DEV_FAULT_I(dflt), .CMP_HOST_FAULT_I(hflt),
        .CMP_ERROR_I(cm[0]), .CMP_SCNT_I(cm[1]), .CMP_SNUM_I(cm[2]), .CMP_CYLL_I(cm[3]), .CMP_CYLH_I(cm[4]),
        .CMP_DEVHD_I(cm[5]), .CMP_STATUS_I(cm[6]), .LOG_REQ_I(req), .LOG_WRITE_I(wr), .LOG_ADDR_I(addr),
        .LOG_SCNT_I(scnt), .LOG_ACK_O(ack), .LOG_FWD_O(fwd), .LOG_ABORT_O(abrt), .BUSY_O(busy), .DATA_O(dat),
        .DATA_VALID_O(dv), .DATA_LAST_O(dl));
    delr_host_model u_host (.clk_i(clk), .busy_i(busy), .ack_i(ack), .fwd_i(fwd), .abort_i(abrt), .data_i(dat),
        .valid_i(dv), .last_i(dl), .req_o(req), .write_o(wr), .addr_o(addr), .scnt_o(scnt));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input int what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t item %0d got %h want %h", $time, what, got, exp);
        end
    endtask
    // one accepted command or hardware reset, task file counting up from b
    task automatic cmd(input logic h, input logic [7:0] b);
        @(posedge clk);
        acc <= 1'b1;
        hw <= h;
        dstate <= 4'h3;
        for (int k = 0; k < 8; k++) tf[k] <= b + 8'(k);
        @(posedge clk);
        acc <= 1'b0;
    endtask
    // completion pulse; waits until any entry write has finished
    task automatic fail(input logic d, input logic h);
        int k;
        @(posedge clk);
        done <= 1'b1;
        dflt <= d;
        hflt <= h;
        for (k = 0; k < 7; k++) cm[k] <= 8'hE0 + 8'(k);
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
    endtask
    task automatic read_sum(input logic [7:0] idx, input logic [7:0] cnt);
        logic [7:0] s;
        s = 8'h00;
        u_host.request(1'b0, 8'h01, 8'h01);
        for (int k = 0; k < 512; k++) s += u_host.sec[k];
        chk(u_host.sec[0], 8'h01, 0);
        chk(u_host.sec[1], idx, 1);
        chk(u_host.sec[452], cnt, 452);
        chk(u_host.sec[453], 8'h00, 453);
        chk(s, 8'h00, 511);
        for (int k = 454; k < 511; k++) chk(u_host.sec[k], 8'h00, k);
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under a millisecond
    initial begin
        #1_000_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        foreach (tf[k]) tf[k] = 8'h00;
        foreach (cm[k]) cm[k] = 8'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[r]) begin
            u_host.request(rows[r][18], rows[r][17:10], rows[r][9:2]);
            chk(8'(u_host.res), 8'(rows[r][1:0]), r);
        end
        u_host.request(1'b0, 8'h00, 8'h01);
        chk(u_host.sec[0], 8'h01, 0);
        chk(u_host.sec[256], 8'h10, 256);
        chk(u_host.sec[318], 8'h10, 318);
        read_sum(8'h00, 8'h00);
        for (i = 2; i < 452; i++) chk(u_host.sec[i], 8'h00, i);
        // a host-caused failure in between must leave no entry behind
        cmd(1'b0, 8'h10);
        fail(1'b0, 1'b1);
        cmd(1'b0, 8'h20);
        fail(1'b1, 1'b0);
        read_sum(8'h01, 8'h01);
        for (i = 2; i < 38; i++) chk(u_host.sec[i], 8'h00, i);
        for (i = 0; i < 8; i++) chk(u_host.sec[38 + i], 8'h10 + 8'(i), 38 + i);
        for (i = 0; i < 8; i++) chk(u_host.sec[50 + i], 8'h20 + 8'(i), 50 + i);
        for (i = 0; i < 7; i++) chk(u_host.sec[63 + i], 8'hE0 + 8'(i), 63 + i);
        chk(u_host.sec[89], 8'h03, 89);
        for (i = 92; i < 452; i++) chk(u_host.sec[i], 8'h00, i);
        // five more failures wrap the ring; the last one follows a hardware reset
        for (int f = 0; f < 5; f++) begin
            cmd(f == 4, 8'h40 + 8'(f * 16));
            fail(1'b1, 1'b0);
        end
        read_sum(8'h01, 8'h06);
        chk(u_host.sec[50], 8'hFF, 50);
        chk(u_host.sec[38], 8'h70, 38);
        chk(u_host.sec[410], 8'h70, 410);
        for (i = 1; i < 8; i++) chk(u_host.sec[50 + i], 8'h00, 50 + i);
        for (i = 1; i < 8; i++) chk(u_host.sec[62 + i], 8'h00, 62 + i);
        // mid-run reset: outputs idle at the first edge and the log reads empty again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({3'h0, busy, ack, fwd, abrt, dv}, 8'h00, 600);
        read_sum(8'h00, 8'h00);
        for (i = 2; i < 452; i++) chk(u_host.sec[i], 8'h00, i);
        conclude();
    end
endmodule // disk_error_log_recorder_test
